// ---- hw/wdog_regs.vh ----
// Constants for the watchdog timeout block: register offsets, fields,
// reset values and timing counts.
// Assumes inclusion by bare name from the design files.
`ifndef WDOG_REGS_VH
`define WDOG_REGS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define WD_CFG_OFS 12'h000
`define WD_CMD_OFS 12'h004
`define WD_STAT_OFS 12'h008
`define WD_IRQ_OFS 12'h00c
`define WD_MASK_OFS 12'h010
`define WD_CNT_OFS 12'h014

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define WD_CFG_RESET 8'h00
`define WD_SEL_W 4
`define WD_CMD_ARM 0
`define WD_CMD_STOP 1
`define WD_EV_EXPIRE 0
`define WD_EV_CFGHIT 1
`define WD_EV_W 2

// ----------------------------------------
// Timing
// ----------------------------------------
`define WD_TICK_DIV 500
`define WD_STEP_TICKS 625
`define WD_RST_PULSE 16

`endif

// ---- hw/tick_divider.v ----
// Divides the master clock down to the watchdog tick.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module tick_divider
#(
  parameter DIV = 500
)
(
  input wire ref_clk,
  input wire rst,
  input wire restart,
  output reg tick
);
  reg [9:0] div_cnt;

  // Count DIV clocks, pulse tick once per period
  always @(posedge ref_clk)
  begin
    if (rst || restart)
    begin
      div_cnt <= 10'h000;
      tick <= 1'b0;
    end
    else if (div_cnt == DIV[9:0] - 10'h001)
    begin
      div_cnt <= 10'h000;
      tick <= 1'b1;
    end
    else
    begin
      div_cnt <= div_cnt + 10'h001;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ---- hw/watchdog_timeout_select.v ----
// Watchdog timeout selection and expiry, with APB register access.
// Assumes APB master on ref_clk; rst synchronous active high.
//
// The register addresses and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "wdog_regs.vh"

// Operation
// [RULE1] Only config bits 3:0 select timeout
// [RULE2] Tick is master clock divided by 500
// [RULE3] Timeout equals tick period times count
// [RULE4] Code 0 one tick, else n*625 ticks
// [RULE5] Expiry while armed drives reset low
// [RULE6] Software refreshes before timeout elapses
// [RULE7] Stop instruction halts the watchdog
// [RULE8] Config write while armed forces reset
// [RULE9] Arm or refresh restarts tick count
module watchdog_timeout_select
#(
  parameter TICK_DIV = `WD_TICK_DIV,
  parameter STEP_TICKS = `WD_STEP_TICKS,
  parameter RST_PULSE = `WD_RST_PULSE
)
(
  input wire ref_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg wdog_reset_n,
  output reg irq
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [7:0] watchdog_timeout_config;
  reg armed;
  reg [13:0] tick_cnt;
  reg [4:0] pulse_cnt;
  reg [`WD_EV_W-1:0] irq_status;
  reg [`WD_EV_W-1:0] irq_mask;
  wire refresh;
  wire watchdog_tick;
  wire wr_ok;
  wire status_clr;
  wire [`WD_EV_W-1:0] next_status;
  wire arm_refresh_instruction;
  wire watchdog_stop_instruction;
  wire cfg_write;
  wire expire;
  wire cfg_hit;
  wire [13:0] limit;
  wire [`WD_EV_W-1:0] events;
  reg [31:0] next_rdata;

  // Timeout in ticks from the selection code
  function [13:0] sel_ticks;
    input [3:0] code;
    begin
      if (code == 4'h0)
        sel_ticks = 14'h0001; // see [RULE4]
      else
        sel_ticks = {10'h000, code} * STEP_TICKS[13:0]; // see [RULE4]
    end
  endfunction

  // Address match for a mapped register
  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `WD_CFG_OFS) || (a == `WD_CMD_OFS) || (a == `WD_STAT_OFS) ||
        (a == `WD_IRQ_OFS) || (a == `WD_MASK_OFS) || (a == `WD_CNT_OFS);
    end
  endfunction

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign wr_ok = psel && penable && pready && pwrite && mapped(paddr);
  assign status_clr = wr_ok && (paddr == `WD_IRQ_OFS);
  assign arm_refresh_instruction = wr_ok && (paddr == `WD_CMD_OFS) && pwdata[`WD_CMD_ARM];
  assign watchdog_stop_instruction = wr_ok && (paddr == `WD_CMD_OFS) && pwdata[`WD_CMD_STOP];
  assign cfg_write = wr_ok && (paddr == `WD_CFG_OFS);
  assign limit = sel_ticks(watchdog_timeout_config[3:0]); // see [RULE1] [RULE3]
  // Stop in the same cycle as the last tick still wins
  assign expire = armed && watchdog_tick && !watchdog_stop_instruction &&
    (tick_cnt + 14'h0001 >= limit); // see [RULE3] [RULE7]
  assign cfg_hit = armed && cfg_write && !watchdog_stop_instruction; // see [RULE8]
  assign events = {cfg_hit, expire};
  // Restart the divider in the command cycle itself: a tick of the old
  // phase must not land on the freshly cleared count
  assign refresh = arm_refresh_instruction && !watchdog_stop_instruction; // see [RULE9]

  // ----------------------------------------
  // Tick generation
  // ----------------------------------------
  // Tick generator, restarted on each arm or refresh
  tick_divider #(.DIV(TICK_DIV)) u_div
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .restart(refresh),
    .tick(watchdog_tick) // see [RULE2]
  );

  // Access ends one cycle after setup; bad address errors
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped(paddr);
      prdata <= next_rdata;
    end
  end

  // Read data mux, captured at end of setup
  always @*
  begin
    next_rdata = 32'h00000000;
    case (paddr)
      `WD_CFG_OFS: next_rdata = {24'h000000, watchdog_timeout_config};
      `WD_STAT_OFS: next_rdata = {31'h00000000, armed};
      `WD_IRQ_OFS: next_rdata = {30'h00000000, irq_status};
      `WD_MASK_OFS: next_rdata = {30'h00000000, irq_mask};
      `WD_CNT_OFS: next_rdata = {18'h00000, tick_cnt};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // ----------------------------------------
  // Watchdog core
  // ----------------------------------------
  // Config, arm state and tick counter
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      watchdog_timeout_config <= `WD_CFG_RESET;
      armed <= 1'b0;
      tick_cnt <= 14'h0000;
    end
    else
    begin
      if (cfg_write)
        watchdog_timeout_config <= pwdata[7:0];
      if (watchdog_stop_instruction || expire || cfg_hit)
      begin
        armed <= 1'b0; // see [RULE7]
        tick_cnt <= 14'h0000;
      end
      else if (arm_refresh_instruction)
      begin
        armed <= 1'b1; // see [RULE5]
        tick_cnt <= 14'h0000; // see [RULE9]
      end
      else if (armed && watchdog_tick)
        tick_cnt <= tick_cnt + 14'h0001;
    end
  end

  // Reset pulse on expiry or config write while armed
  // A later event during a pulse restarts its full length
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      pulse_cnt <= 5'h00;
      wdog_reset_n <= 1'b1;
    end
    else if (expire || cfg_hit)
    begin
      pulse_cnt <= RST_PULSE[4:0]; // see [RULE5] [RULE8]
      wdog_reset_n <= 1'b0;
    end
    else if (pulse_cnt != 5'h00)
    begin
      pulse_cnt <= pulse_cnt - 5'h01;
      wdog_reset_n <= (pulse_cnt == 5'h01);
    end
    else
      wdog_reset_n <= 1'b1;
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  // Next status per event bit; set wins over a write-one clear
  genvar ev;
  generate
    for (ev = 0; ev < `WD_EV_W; ev = ev + 1)
    begin : g_status
      assign next_status[ev] = events[ev] ||
        (irq_status[ev] && !(status_clr && pwdata[ev]));
    end
  endgenerate

  // Sticky status, write one to clear, set wins
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      irq_status <= 2'h0;
      irq_mask <= 2'h0;
      irq <= 1'b0;
    end
    else
    begin
      irq_status <= next_status;
      if (wr_ok && paddr == `WD_MASK_OFS)
        irq_mask <= pwdata[1:0];
      irq <= |(irq_status & irq_mask);
    end
  end
endmodule
`default_nettype wire

// ---- bench/wdog_chk_assertions.sv ----
// Port checker for the watchdog block.
// Assumes binding into watchdog_timeout_select.
`timescale 1ns/1ps
`default_nettype none
module wdog_chk
(
  input wire ref_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire wdog_reset_n,
  input wire irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Bus phases
  wire setup = psel && !penable;
  wire stop_wr = pready && pwrite && paddr == 12'h004 && pwdata[1];
  chk_ready_setup: assert property (setup |=> pready) else $error("pready late");
  chk_ready_cause: assert property (pready |-> penable && $past(setup)) else $error("stray pready");
  chk_err_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
  chk_bad_addr: assert property (setup && paddr > 12'h014 |=> pslverr) else $error("no pslverr");
  chk_good_addr: assert property (setup && paddr < 12'h018 && paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("false pslverr");
  chk_pulse_len:
    assert property ($fell(wdog_reset_n) |-> !wdog_reset_n [*8] ##1 !wdog_reset_n [*8] ##1
      wdog_reset_n) else $error("pulse length");
  chk_stop_quiet:
    assert property (stop_wr && wdog_reset_n |=> wdog_reset_n [*4]) else $error("stop ignored");
  chk_reset_out: assert property ($past(rst) |-> wdog_reset_n && !pready && !irq)
    else $error("reset outputs");
  cover property (!wdog_reset_n);
  cover property (irq);
  cover property (pslverr);
endmodule
bind watchdog_timeout_select wdog_chk u_chk
(
  .ref_clk(ref_clk),
  .rst(rst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .wdog_reset_n(wdog_reset_n),
  .irq(irq)
);
`default_nettype wire

// ---- bench/watchdog_timeout_select_bench.sv ----
// Bench for the watchdog block.
// Assumes the hw/ design files.
`timescale 1ns/1ps
`default_nettype none
module watchdog_timeout_select_bench;
  logic ref_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic pready, pslverr, wdog_reset_n, irq, er;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int failures = 0, n_tests = 0, low = 0, cyc = 0, seed = 32'hf9ba, k, m, n;
  // Register model: config, armed, status, mask, expected read queue
  int m_cfg = 0, m_arm = 0, m_irq = 0, m_mask = 0, x;
  int exp_q[$];
  watchdog_timeout_select #(.TICK_DIV(4), .STEP_TICKS(3)) u_dut
  (
    .ref_clk(ref_clk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .wdog_reset_n(wdog_reset_n),
    .irq(irq)
  );
  initial forever #4 ref_clk = ~ref_clk;
  // Pulse cycle count and hang limit
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    low <= low + !wdog_reset_n;
    if (cyc == 9000)
    begin
      failures++;
      results;
    end
  end
  task chk(input logic [31:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      failures++;
      $display("Error %0t: %h not %h", $time, s, e);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    exp_q.push_back(a == 12'h000 ? m_cfg : a == 12'h008 ? m_arm : a == 12'h00c ? m_irq :
      a == 12'h010 ? m_mask : 0);
    @(posedge ref_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'h1;
    do @(posedge ref_clk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    x = exp_q.pop_front();
    if (!w && a != 12'h014)
      chk(rd, x);
    if (w && a == 12'h000)
    begin
      m_irq = m_irq | 2 * m_arm;
      m_arm = 0;
      m_cfg = d[7:0];
    end
    if (w && a == 12'h004)
      m_arm = d[1] ? 0 : d[0] ? 1 : m_arm;
    if (w && a == 12'h00c)
      m_irq = m_irq & ~d[1:0];
    if (w && a == 12'h010)
      m_mask = d[1:0];
  endtask
  task results;
    $display("%0d checks %0d failures", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'h0;
    m = 0;
    for (k = 0; k < 16; k++)
    begin
      apb(1'h0, 12'h000, 0);
      chk(rd, m);
      m = {$random(seed)} % 16 * 16 + k;
      apb(1'h1, 12'h000, m);
      apb(1'h1, 12'h004, 32'h1);
      n = (k ? k * 3 : 1) * 4;
      while (wdog_reset_n === 1'h1) @(posedge ref_clk) n--;
      chk({31'h0, n <= 0 && n >= -4}, 32'h1);
      m_irq = m_irq | 1;
      m_arm = 0;
      repeat (20) @(posedge ref_clk);
    end
    $display("codes done");
    apb(1'h1, 12'h000, 32'h2);
    apb(1'h1, 12'h004, 32'h1);
    m = low;
    repeat (6)
    begin
      repeat (14) @(posedge ref_clk);
      apb(1'h1, 12'h004, 32'h1);
    end
    apb(1'h0, 12'h008, 32'h0);
    chk(low, m);
    apb(1'h1, 12'h004, 32'h2);
    repeat (60) @(posedge ref_clk);
    apb(1'h0, 12'h008, 32'h0);
    chk(low, m);
    $display("refresh done");
    apb(1'h1, 12'h004, 32'h1);
    apb(1'h1, 12'h000, 32'hf);
    repeat (30) @(posedge ref_clk);
    chk(low, m + 16);
    apb(1'h0, 12'h00c, 32'h0);
    chk(rd, 32'h3);
    apb(1'h1, 12'h010, 32'h3);
    apb(1'h0, 12'h010, 32'h0);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h1);
    apb(1'h1, 12'h00c, 32'h3);
    repeat (2) @(posedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    apb(1'h0, 12'h020, 32'h0);
    chk({er, rd[30:0]}, 32'h80000000);
    $display("irq done");
    results;
  end
endmodule
`default_nettype wire
